//--- hdl/sie_pkg.sv
// constants and carrier types for the stack and interrupt entry block
// assumes one undivided core clock and a pipeline that reports retirements
package sie_pkg;

   // ==========================================================
   // register map, io space
   localparam logic [5:0] IO_SP_LOW = 6'h3D;
   localparam logic [5:0] IO_SP_HIGH = 6'h3E;
   localparam logic [7:0] SP_BYTE_RST = 8'h00;
   localparam int STATUS_REGISTER_GIE_BIT = 7;

   // ==========================================================
   // timing, in core clock cycles
   localparam logic [2:0] ENTRY_CYC = 3'h4;
   localparam logic [2:0] EXIT_CYC = 3'h4;
   localparam logic [2:0] WAKE_EXTRA_CYC = 3'h4;

   // ==========================================================
   // vector layout: reset at base, source i at base + (i + 1) * stride
   localparam int VEC_STRIDE = 2;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      ST_RUN,
      ST_WAKE,
      ST_ENTRY,
      ST_EXIT
   } sie_state_t;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_PUSH,
      OP_POP,
      OP_CALL,
      OP_RET,
      OP_HANDLER_EXIT_INSTRUCTION,
      OP_SEI,
      OP_CLI
   } sie_op_t;

   typedef struct packed {
      logic valid;
      sie_op_t op;
   } sie_instr_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } sie_io_req_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [15:0] addr;
      logic [7:0] wdata;
   } sie_mem_req_t;

endpackage

//--- hdl/sie_flag_bank.sv
// pending flags of the flag-type interrupt sources
// assumes event pulses synchronous to sys_clk; level sources keep no flag
`timescale 1ns/1ns
`default_nettype none
module sie_flag_bank #(
   parameter int N = 8,
   parameter logic [N-1:0] LEVEL_MASK = '0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // set and clear
   input wire logic [N-1:0] event_in,
   input wire logic [N-1:0] clr_hw,
   input wire logic [N-1:0] clr_sw,
   // state
   output logic [N-1:0] flags_out
);
   typedef struct packed {
      logic [N-1:0] flag;
   } sie_flag_st_t;

   sie_flag_st_t st_q;
   sie_flag_st_t st_d;
   logic [N-1:0] nxt;

   // ==========================================================
   // per-source flag: a new event beats a clear in the same cycle
   for (genvar i = 0; i < N; i++) begin : g_flag
      assign nxt[i] = LEVEL_MASK[i] ? 1'b0 :
         (event_in[i] | (st_q.flag[i] & ~clr_hw[i] & ~clr_sw[i]));
   end

   always_comb begin
      st_d = st_q;
      st_d.flag = nxt;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign flags_out = st_q.flag;
endmodule
`default_nettype wire

//--- hdl/sie_prio_enc.sv
// fixed priority pick: lowest index wins
// assumes requests already gated by their enables
`timescale 1ns/1ns
`default_nettype none
module sie_prio_enc #(
   parameter int N = 8,
   parameter int IDX_W = 3
) (
   // requests
   input wire logic [N-1:0] req,
   // winner
   output logic any,
   output logic [IDX_W-1:0] idx
);
   always_comb begin
      any = |req;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = IDX_W'(i);
         end
      end
   end
endmodule
`default_nettype wire

//--- hdl/sie_core.sv
// stack pointer upkeep and interrupt acceptance, entry and return
// assumes the pipeline retires one instruction per instr.valid pulse and
// stalls while core_hold is high; stack memory answers reads one cycle late
//
// Function
// - stack grows downward; pushing lowers pointer
// - push lowers pointer one, pop raises one
// - call or interrupt entry lowers pointer two
// - return or handler exit raises pointer two
// - pointer is two bytes, read/write, reset zero
// - core clock used undivided
// - accept needs own enable and global enable
// - boot locks mask interrupts by program counter
// - lower vector wins; reset vector at base
// - relocation bit and fuse move vectors
// - acceptance clears global enable
// - handler exit sets global enable
// - vectoring or write-one clears pending flag
// - disabled flag events are held pending
// - level sources request only while present
// - one main instruction runs after handler exit
// - mask instruction blocks interrupts at once
// - instruction after unmask always runs first
// - entry four cycles, pushing the program counter
// - sleep adds four; exit takes four cycles
// - global enable is status bit seven
`timescale 1ns/1ns
`default_nettype none
module sie_core #(
   parameter int N_SRC = 8,
   parameter logic [N_SRC-1:0] LEVEL_MASK = '0,
   parameter int PC_W = 15,
   parameter logic [PC_W-1:0] BOOT_START = '0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // io register port
   input wire sie_pkg::sie_io_req_t io_req,
   output logic [7:0] io_rdata,
   // status register, global enable bit
   input wire logic status_register_wr,
   input wire logic [7:0] status_register_wdata,
   output logic gie,
   // pipeline
   input wire sie_pkg::sie_instr_t instr,
   input wire logic core_asleep,
   input wire logic [PC_W-1:0] pc_now,
   output logic core_hold,
   output logic vec_valid,
   output logic [PC_W-1:0] vec_addr,
   output logic pc_load,
   output logic [PC_W-1:0] pc_ret,
   output logic [15:0] stack_pointer,
   // stack memory
   output sie_pkg::sie_mem_req_t mem,
   input wire logic [7:0] mem_rdata,
   // interrupt sources
   input wire logic [N_SRC-1:0] src_event,
   input wire logic [N_SRC-1:0] src_level,
   input wire logic [N_SRC-1:0] src_en,
   input wire logic flag_clr_wr,
   input wire logic [N_SRC-1:0] flag_clr_mask,
   output logic [N_SRC-1:0] flags,
   // vector placement and locks
   input wire logic vec_reloc,
   input wire logic reset_reloc_fuse,
   input wire logic boot_lock_a,
   input wire logic boot_lock_b,
   output logic [PC_W-1:0] reset_vector
);
   localparam int IDX_W = (N_SRC > 1) ? $clog2(N_SRC) : 1;

   typedef struct packed {
      sie_pkg::sie_state_t state;
      logic [2:0] cnt;
      logic [15:0] sp;
      logic gie;
      logic [PC_W-1:0] ret_pc;
      logic [PC_W-1:0] vec;
      logic vec_valid;
      logic pc_load;
      logic [7:0] rdata;
   } sie_core_st_t;

   sie_core_st_t st_q;
   sie_core_st_t st_d;

   logic [N_SRC-1:0] req;
   logic [N_SRC-1:0] ack;
   logic req_any;
   logic [IDX_W-1:0] req_idx;
   logic [PC_W-1:0] vec_base;
   logic in_boot;
   logic lock_block;
   logic mask_now;
   logic take;
   logic [15:0] pc_wide;

   // ==========================================================
   // sources
   sie_flag_bank #(
      .N(N_SRC),
      .LEVEL_MASK(LEVEL_MASK)
   ) u_flags (
      .sys_clk(sys_clk),
      .srst(srst),
      .event_in(src_event),
      .clr_hw(ack),
      .clr_sw(flag_clr_wr ? flag_clr_mask : '0),
      .flags_out(flags)
   );

   // level sources look at the live condition, never at a stored copy
   assign req = src_en & ((LEVEL_MASK & src_level) | (~LEVEL_MASK & flags));

   sie_prio_enc #(
      .N(N_SRC),
      .IDX_W(IDX_W)
   ) u_prio (
      .req(req),
      .any(req_any),
      .idx(req_idx)
   );

   // ==========================================================
   // vector placement and lock masking
   assign vec_base = vec_reloc ? BOOT_START : '0;
   assign reset_vector = reset_reloc_fuse ? BOOT_START : '0;
   assign in_boot = (pc_now >= BOOT_START);
   // a lock forbids jumping across into the other section's vector table
   assign lock_block = (boot_lock_a & ~in_boot & vec_reloc) |
      (boot_lock_b & in_boot & ~vec_reloc);

   // mask instruction or a status write clearing the bit acts this very cycle
   assign mask_now = (instr.valid & (instr.op == sie_pkg::OP_CLI)) |
      (status_register_wr & ~status_register_wdata[sie_pkg::STATUS_REGISTER_GIE_BIT]);

   // accepted only at an instruction boundary, so a multi-cycle op finishes
   assign take = (st_q.state == sie_pkg::ST_RUN) & req_any & st_q.gie & ~mask_now &
      ~lock_block & (core_asleep | (instr.valid & (instr.op != sie_pkg::OP_HANDLER_EXIT_INSTRUCTION)));

   // hardware clear of the served flag when vectoring
   assign ack = take ? (N_SRC'(1) << req_idx) & ~LEVEL_MASK : '0;

   assign pc_wide = 16'(st_q.ret_pc);

   // ==========================================================
   // next state
   always_comb begin
      st_d = st_q;
      st_d.vec_valid = 1'b0;
      st_d.pc_load = 1'b0;
      st_d.rdata = mem_rdata;
      mem = '0;
      unique case (st_q.state)
         sie_pkg::ST_RUN: begin
            if (instr.valid) begin
               unique case (instr.op)
                  sie_pkg::OP_PUSH: st_d.sp = st_q.sp - 16'h0001;
                  sie_pkg::OP_POP: st_d.sp = st_q.sp + 16'h0001;
                  sie_pkg::OP_CALL: st_d.sp = st_q.sp - 16'h0002;
                  sie_pkg::OP_RET: st_d.sp = st_q.sp + 16'h0002;
                  sie_pkg::OP_HANDLER_EXIT_INSTRUCTION: begin
                     st_d.state = sie_pkg::ST_EXIT;
                     st_d.cnt = '0;
                  end
                  // global enable is registered, so the next op always retires first
                  sie_pkg::OP_SEI: st_d.gie = 1'b1;
                  sie_pkg::OP_CLI: st_d.gie = 1'b0;
                  sie_pkg::OP_NONE: begin
                  end
               endcase
            end
            if (status_register_wr) begin
               st_d.gie = status_register_wdata[sie_pkg::STATUS_REGISTER_GIE_BIT];
            end
            if (take) begin
               st_d.gie = 1'b0;
               st_d.ret_pc = pc_now;
               st_d.vec = vec_base + PC_W'((int'(req_idx) + 1) * sie_pkg::VEC_STRIDE);
               st_d.cnt = '0;
               st_d.state = core_asleep ? sie_pkg::ST_WAKE : sie_pkg::ST_ENTRY;
            end
         end
         sie_pkg::ST_WAKE: begin
            st_d.cnt = st_q.cnt + 3'h1;
            if (st_q.cnt == sie_pkg::WAKE_EXTRA_CYC - 3'h1) begin
               st_d.cnt = '0;
               st_d.state = sie_pkg::ST_ENTRY;
            end
         end
         sie_pkg::ST_ENTRY: begin
            st_d.cnt = st_q.cnt + 3'h1;
            if (st_q.cnt < 3'h2) begin
               mem.we = 1'b1;
               mem.addr = st_q.sp;
               // low byte lands first at the higher address
               mem.wdata = (st_q.cnt == 3'h0) ? pc_wide[7:0] : pc_wide[15:8];
               st_d.sp = st_q.sp - 16'h0001;
            end
            if (st_q.cnt == sie_pkg::ENTRY_CYC - 3'h1) begin
               st_d.vec_valid = 1'b1;
               st_d.state = sie_pkg::ST_RUN;
            end
         end
         sie_pkg::ST_EXIT: begin
            st_d.cnt = st_q.cnt + 3'h1;
            if (st_q.cnt < 3'h2) begin
               mem.re = 1'b1;
               mem.addr = st_q.sp + 16'h0001;
               st_d.sp = st_q.sp + 16'h0001;
            end
            if (st_q.cnt == 3'h2) begin
               st_d.ret_pc = PC_W'({st_q.rdata, mem_rdata}); // high came first
            end
            if (st_q.cnt == sie_pkg::EXIT_CYC - 3'h1) begin
               st_d.gie = 1'b1;
               st_d.pc_load = 1'b1;
               st_d.state = sie_pkg::ST_RUN;
            end
         end
      endcase
      // software byte writes of the pointer win over any adjustment
      // a pointer left below the data area is not caught here
      if (io_req.wr && io_req.addr == sie_pkg::IO_SP_LOW) begin
         st_d.sp[7:0] = io_req.wdata;
      end
      if (io_req.wr && io_req.addr == sie_pkg::IO_SP_HIGH) begin
         st_d.sp[15:8] = io_req.wdata;
      end
   end

   // core clock taken straight from sys_clk, no divider
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.sp <= {sie_pkg::SP_BYTE_RST, sie_pkg::SP_BYTE_RST};
         st_q.state <= sie_pkg::ST_RUN;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // io read data, one cycle after the strobe
   logic [7:0] io_rdata_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         io_rdata_q <= 8'h00;
      end else if (io_req.rd) begin
         unique case (io_req.addr)
            sie_pkg::IO_SP_LOW: io_rdata_q <= st_q.sp[7:0];
            sie_pkg::IO_SP_HIGH: io_rdata_q <= st_q.sp[15:8];
            default: io_rdata_q <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // outputs
   assign io_rdata = io_rdata_q;
   assign gie = st_q.gie;
   assign core_hold = (st_q.state != sie_pkg::ST_RUN);
   assign vec_valid = st_q.vec_valid;
   assign vec_addr = st_q.vec;
   assign pc_load = st_q.pc_load;
   assign pc_ret = st_q.ret_pc;
   assign stack_pointer = st_q.sp;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic run_op;
   logic sp_io_wr;
   assign sp_io_wr = io_req.wr &&
      (io_req.addr == sie_pkg::IO_SP_LOW || io_req.addr == sie_pkg::IO_SP_HIGH);
   assign run_op = instr.valid && (st_q.state == sie_pkg::ST_RUN) && !sp_io_wr && !take;

   a_push_dec: assert property (run_op && instr.op == sie_pkg::OP_PUSH
      |=> stack_pointer == $past(stack_pointer) - 16'h0001)
      else $error("push did not lower pointer by one");
   a_pop_inc: assert property (run_op && instr.op == sie_pkg::OP_POP
      |=> stack_pointer == $past(stack_pointer) + 16'h0001)
      else $error("pop did not raise pointer by one");
   a_call_dec_two: assert property (run_op && instr.op == sie_pkg::OP_CALL
      |=> stack_pointer == $past(stack_pointer) - 16'h0002)
      else $error("call did not lower pointer by two");
   a_ret_inc_two: assert property (run_op && instr.op == sie_pkg::OP_RET
      |=> stack_pointer == $past(stack_pointer) + 16'h0002)
      else $error("return did not raise pointer by two");
   // the take cycle is not counted: four hold cycles, vector pulse on the fifth
   a_entry_timing: assert property (take && !core_asleep && !sp_io_wr
      |=> !vec_valid [*4]
      ##1 (vec_valid && stack_pointer == $past(stack_pointer, 5) - 16'h0002))
      else $error("entry length or pointer wrong");
   a_sleep_entry: assert property (take && core_asleep |-> ##9 vec_valid)
      else $error("wake entry not eight cycles");
   a_exit_timing: assert property (run_op && instr.op == sie_pkg::OP_HANDLER_EXIT_INSTRUCTION
      |-> ##5 (pc_load && gie && stack_pointer == $past(stack_pointer, 5) + 16'h0002))
      else $error("handler exit length, enable or pointer wrong");
   a_exit_pops: assert property (run_op && instr.op == sie_pkg::OP_HANDLER_EXIT_INSTRUCTION
      |=> (mem.re && mem.addr == stack_pointer + 16'h0001) [*2])
      else $error("handler exit pops misplaced");
   a_accept_gated: assert property (take |-> gie && !lock_block &&
      (src_en & ((flags & ~LEVEL_MASK) | (src_level & LEVEL_MASK))) != '0)
      else $error("interrupt taken while disabled");
   a_accept_clears: assert property (take |=> !gie && core_hold)
      else $error("global enable not cleared on entry");
   a_mask_now: assert property (instr.valid && instr.op == sie_pkg::OP_CLI |-> !take)
      else $error("interrupt taken with mask instruction");
   a_sei_defers: assert property (instr.valid && instr.op == sie_pkg::OP_SEI
      && !gie |-> !take)
      else $error("interrupt taken on the unmask instruction");
   a_lock_blocks: assert property (boot_lock_a && vec_reloc && pc_now < BOOT_START
      |-> !take)
      else $error("interrupt taken across a locked section");
   a_entry_writes: assert property (take && !core_asleep
      |=> mem.we && mem.addr == stack_pointer
      ##1 mem.we && mem.addr == $past(stack_pointer) - 16'h0001)
      else $error("entry pushes misplaced");
   // a fresh event on the same source outranks either clear
   a_hw_clear: assert property (take && src_event == '0
      |=> (flags & ~LEVEL_MASK & (N_SRC'(1) << $past(req_idx))) == '0)
      else $error("served flag not cleared");
   a_sw_clear: assert property (flag_clr_wr && (src_event & flag_clr_mask) == '0
      |=> (flags & $past(flag_clr_mask)) == '0)
      else $error("written flag not cleared");
   a_flag_held: assert property ((src_event & ~LEVEL_MASK) != '0
      |=> (flags & $past(src_event) & ~LEVEL_MASK) == ($past(src_event) & ~LEVEL_MASK))
      else $error("event did not set its flag");

   c_entry: cover property (take && !core_asleep ##5 vec_valid);
   c_wake: cover property (take && core_asleep);
   c_exit_then_take: cover property (pc_load ##[1:20] take);
   c_nested: cover property (vec_valid ##[1:20] take);
   c_locked: cover property (req_any && gie && lock_block && instr.valid);
endmodule
`default_nettype wire

//--- tb/sie_stack_mem.sv
// behavioural stack memory on the far side of the core's stack port
// assumes requests are taken on the rising edge; read data one cycle late
`timescale 1ns/1ns
`default_nettype none
module sie_stack_mem (
   // clock
   input wire logic sys_clk,
   // stack port
   input wire sie_pkg::sie_mem_req_t mem,
   output logic [7:0] mem_rdata
);
   // ==========================================================
   // storage
   logic [7:0] ram [0:65535];

   initial begin
      mem_rdata = 8'h00;
   end

   // data is valid only the cycle after a read; otherwise it drifts away
   always @(posedge sys_clk) begin
      if (mem.we) begin
         ram[mem.addr] <= mem.wdata;
      end
      if (mem.re) begin
         mem_rdata <= ram[mem.addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule
`default_nettype wire

//--- tb/sie_core_tb.sv
// self-checking bench for the stack and interrupt entry core
// assumes the pipeline side is driven here at the falling edge
`timescale 1ns/1ns
`default_nettype none
module sie_core_tb;
   localparam logic [14:0] BOOT = 15'h4000;
   logic sys_clk, srst, status_register_wr, gie, core_asleep, core_hold, vec_valid, pc_load;
   logic flag_clr_wr, vec_reloc, reset_reloc_fuse, boot_lock_a, boot_lock_b;
   logic [7:0] io_rdata, status_register_wdata, mem_rdata;
   logic [7:0] src_event, src_level, src_en, flag_clr_mask, flags;
   logic [14:0] pc_now, vec_addr, pc_ret, reset_vector;
   logic [15:0] stack_pointer;
   sie_pkg::sie_io_req_t io_req;
   sie_pkg::sie_instr_t instr;
   sie_pkg::sie_mem_req_t mem;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   logic [7:0] status_register_saved;

   // ==========================================================
   // design and far side
   sie_core #(.N_SRC(8), .LEVEL_MASK(8'h80), .PC_W(15), .BOOT_START(BOOT)) DUT (
      .sys_clk(sys_clk), .srst(srst), .io_req(io_req), .io_rdata(io_rdata),
      .status_register_wr(status_register_wr), .status_register_wdata(status_register_wdata), .gie(gie), .instr(instr),
      .core_asleep(core_asleep), .pc_now(pc_now), .core_hold(core_hold),
      .vec_valid(vec_valid), .vec_addr(vec_addr), .pc_load(pc_load), .pc_ret(pc_ret),
      .stack_pointer(stack_pointer), .mem(mem), .mem_rdata(mem_rdata),
      .src_event(src_event), .src_level(src_level), .src_en(src_en),
      .flag_clr_wr(flag_clr_wr), .flag_clr_mask(flag_clr_mask), .flags(flags),
      .vec_reloc(vec_reloc), .reset_reloc_fuse(reset_reloc_fuse),
      .boot_lock_a(boot_lock_a), .boot_lock_b(boot_lock_b), .reset_vector(reset_vector));
   sie_stack_mem mdl (.sys_clk(sys_clk), .mem(mem), .mem_rdata(mem_rdata));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // tasks
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk);
      io_req = '0;
   endtask

   task automatic io_rd(input logic [5:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk);
      io_req = '0;
      chk("io read", 16'(io_rdata), 16'(exp));
   endtask

   task automatic retire(input sie_pkg::sie_op_t op);
      @(negedge sys_clk);
      instr = '{valid: 1'b1, op: op};
      @(negedge sys_clk);
      instr = '0;
   endtask

   // counts edges after the take (or the exit start) until the pulse stands
   task automatic count_until(input bit for_load, input int exp_n);
      n = 0;
      while ((for_load ? pc_load : vec_valid) !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      chk(for_load ? "exit cycles" : "entry cycles", 16'(n), 16'(exp_n));
   endtask

   task automatic wait_vec(input logic [14:0] exp_vec, input int exp_n);
      count_until(1'b0, exp_n);
      chk("vector", 16'(vec_addr), 16'(exp_vec));
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         complete_run();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      io_req = '0; instr = '0; status_register_wr = 1'b0; status_register_wdata = 8'h00; core_asleep = 1'b0;
      pc_now = 15'h1234; src_event = 8'h00; src_level = 8'h00; src_en = 8'h00;
      flag_clr_wr = 1'b0; flag_clr_mask = 8'h00; vec_reloc = 1'b0;
      reset_reloc_fuse = 1'b0; boot_lock_a = 1'b0; boot_lock_b = 1'b0; srst = 1'b1;
      repeat (10) @(negedge sys_clk);
      srst = 1'b0;
      io_rd(6'h3D, 8'h00);
      io_rd(6'h3E, 8'h00);
      chk("gie", 16'(gie), 16'h0000);
      chk("reset vector", 16'(reset_vector), 16'h0000);
      reset_reloc_fuse = 1'b1;
      @(negedge sys_clk);
      chk("reset vector", 16'(reset_vector), 16'(BOOT));
      io_wr(6'h3E, 8'h02);
      io_wr(6'h3D, 8'h00);
      io_rd(6'h3E, 8'h02);
      io_rd(6'h3F, 8'h00);
      retire(sie_pkg::OP_PUSH);
      chk("sp", stack_pointer, 16'h01FF);
      retire(sie_pkg::OP_POP);
      chk("sp", stack_pointer, 16'h0200);
      retire(sie_pkg::OP_CALL);
      chk("sp", stack_pointer, 16'h01FE);
      retire(sie_pkg::OP_RET);
      chk("sp", stack_pointer, 16'h0200);
      // flags raised while disabled, then served by priority
      @(negedge sys_clk);
      src_event = 8'h24;
      @(negedge sys_clk);
      src_event = 8'h00;
      status_register_wr = 1'b1;
      status_register_wdata = 8'h80;
      @(negedge sys_clk);
      status_register_wr = 1'b0;
      chk("gie", 16'(gie), 16'h0001);
      retire(sie_pkg::OP_NONE);
      chk("hold", 16'(core_hold), 16'h0000);
      chk("flags", 16'(flags), 16'h0024);
      src_en = 8'h24;
      retire(sie_pkg::OP_NONE);
      chk("gie", 16'(gie), 16'h0000);
      chk("flags", 16'(flags), 16'h0020);
      wait_vec(15'h0006, 4);
      chk("sp", stack_pointer, 16'h01FE);
      chk("pushed low", 16'(mdl.ram[16'h0200]), 16'h0034);
      chk("pushed high", 16'(mdl.ram[16'h01FF]), 16'h0012);
      retire(sie_pkg::OP_HANDLER_EXIT_INSTRUCTION);
      count_until(1'b1, 4);
      chk("return pc", 16'(pc_ret), 16'h1234);
      chk("gie", 16'(gie), 16'h0001);
      chk("sp", stack_pointer, 16'h0200);
      repeat (2) @(negedge sys_clk);
      chk("hold", 16'(core_hold), 16'h0000);
      retire(sie_pkg::OP_NONE);
      wait_vec(15'h000C, 4);
      // the handler keeps its own copy of the status register
      status_register_saved = {gie, 7'h00};
      @(negedge sys_clk);
      status_register_wr = 1'b1;
      status_register_wdata = status_register_saved;
      @(negedge sys_clk);
      status_register_wr = 1'b0;
      chk("gie", 16'(gie), 16'h0000);
      retire(sie_pkg::OP_HANDLER_EXIT_INSTRUCTION);
      count_until(1'b1, 4);
      // a flag raised just before the mask instruction retires
      @(negedge sys_clk);
      src_en = 8'h02;
      src_event = 8'h02;
      @(negedge sys_clk);
      src_event = 8'h00;
      instr = '{valid: 1'b1, op: sie_pkg::OP_CLI};
      @(negedge sys_clk);
      instr = '0;
      chk("hold", 16'(core_hold), 16'h0000);
      chk("gie", 16'(gie), 16'h0000);
      retire(sie_pkg::OP_SEI);
      chk("hold", 16'(core_hold), 16'h0000);
      vec_reloc = 1'b1;
      boot_lock_a = 1'b1;
      retire(sie_pkg::OP_NONE);
      chk("hold", 16'(core_hold), 16'h0000);
      boot_lock_a = 1'b0;
      retire(sie_pkg::OP_NONE);
      wait_vec(15'h4004, 4);
      retire(sie_pkg::OP_HANDLER_EXIT_INSTRUCTION);
      count_until(1'b1, 4);
      vec_reloc = 1'b0;
      // software clear of a held flag, and a level that vanishes early
      @(negedge sys_clk);
      src_en = 8'h00;
      src_event = 8'h08;
      src_level = 8'h80;
      @(negedge sys_clk);
      src_event = 8'h00;
      flag_clr_wr = 1'b1;
      flag_clr_mask = 8'h08;
      @(negedge sys_clk);
      flag_clr_wr = 1'b0;
      src_level = 8'h00;
      chk("flags", 16'(flags), 16'h0000);
      src_en = 8'h88;
      retire(sie_pkg::OP_NONE);
      chk("hold", 16'(core_hold), 16'h0000);
      // wake from sleep by a level source
      @(negedge sys_clk);
      core_asleep = 1'b1;
      src_level = 8'h80;
      @(negedge sys_clk);
      wait_vec(15'h0010, 8);
      src_level = 8'h00;
      core_asleep = 1'b0;
      repeat (2) @(negedge sys_clk);
      complete_run();
   end
endmodule
`default_nettype wire
